// *** design/erb_pkg.sv ***
// Shared constants and types for the embedded RAM block
package erb_pkg;
    localparam int ADDR_W      = 11;
    localparam int DATA_W      = 8;
    localparam int ROWS        = 256;
    localparam int ROW_W       = 8;
    localparam int ROW_AW      = 8;
    localparam int COL_W       = 3;
    localparam int TOTAL_BITS  = 2048;
    localparam int CNT_W       = 12;
    localparam logic [CNT_W-1:0]  BASE_DEPTH = 12'h100;
    localparam logic [ADDR_W-1:0] FULL_MASK  = 11'h7ff;
    localparam logic [ROW_W-1:0]  DATA_RST   = 8'h00;

    typedef enum logic [1:0] {
        ERB_RAM   = 2'b00,
        ERB_ROM   = 2'b01,
        ERB_DPRAM = 2'b11,
        ERB_FIFO  = 2'b10
    } erb_mode_t;

    typedef enum logic [1:0] {
        ERB_X8 = 2'b00,
        ERB_X4 = 2'b01,
        ERB_X2 = 2'b10,
        ERB_X1 = 2'b11
    } erb_width_t;

    typedef enum logic [1:0] {
        ERB_SRC_GLB = 2'b00,
        ERB_SRC_PIN = 2'b01,
        ERB_SRC_LOC = 2'b11
    } erb_src_t;
endpackage

// *** design/erb_pin_sync.sv ***
// Two-stage synchroniser with rising-edge pulse for a pin clock
`timescale 1ns/1ps
`default_nettype none
module erb_pin_sync (
    input  wire logic i_clk,
    input  wire logic i_rst_b,
    input  wire logic i_pin,
    output logic      o_rise
);
    logic meta_q;
    logic sync_q;
    logic last_q;

    always_ff @(posedge i_clk) begin
        if (!i_rst_b) begin
            meta_q <= 1'b0;
            sync_q <= 1'b0;
            last_q <= 1'b0;
        end else begin
            meta_q <= i_pin;
            sync_q <= meta_q;
            last_q <= sync_q;
        end
    end

    assign o_rise = sync_q & ~last_q;
endmodule
`default_nettype wire

// *** design/erb_store.sv ***
// 2048-bit storage array, 256 rows of 8 bits, bit-masked write
`timescale 1ns/1ps
`default_nettype none
module erb_store #(
    parameter logic [erb_pkg::TOTAL_BITS-1:0] INIT = '0
) (
    input  wire logic                        i_clk,
    input  wire logic                        i_rst_b,
    input  wire logic                        i_we,
    input  wire logic [erb_pkg::ROW_AW-1:0]  i_wr_row,
    input  wire logic [erb_pkg::ROW_W-1:0]   i_bit_mask,
    input  wire logic [erb_pkg::ROW_W-1:0]   i_bit_data,
    input  wire logic [erb_pkg::ROW_AW-1:0]  i_rd_row,
    output logic      [erb_pkg::ROW_W-1:0]   o_rd_data
);
    logic [erb_pkg::ROW_W-1:0] mem_q [erb_pkg::ROWS];

    genvar r;
    generate
        for (r = 0; r < erb_pkg::ROWS; r++) begin : g_row
            always_ff @(posedge i_clk) begin
                if (!i_rst_b) begin
                    // Preload fixed pattern, as at configuration
                    mem_q[r] <= INIT[r*erb_pkg::ROW_W +: erb_pkg::ROW_W];
                end else if (i_we && i_wr_row == erb_pkg::ROW_AW'(r)) begin
                    mem_q[r] <= (mem_q[r] & ~i_bit_mask)
                              | (i_bit_data & i_bit_mask);
                end
            end
        end
    endgenerate

    assign o_rd_data = mem_q[i_rd_row];
endmodule
`default_nettype wire

// *** design/erb_embedded_ram_block.sv ***
// Configurable 2048-bit embedded RAM block: RAM, ROM, dual-port, FIFO
`timescale 1ns/1ps
`default_nettype none
// How it works
// - Holds 2048 bits; modes are RAM, ROM, dual-port RAM or FIFO.
// - ROM mode returns a pattern preloaded at reset, writes are blocked.
// - Organisation selectable as 256x8, 512x4, 1024x2 or 2048x1.
// - Write pulse made internally on the input tick; user only sets up inputs.
// - Input-side and output-side registers run on independent clock enables.
// - Data-in, data-out and address/write-enable registers each bypassable.
// - Write enable taken from global or local source.
// - Each clock enable from global, synchronised pin, or local source.
// - Blocks sharing an address combine side by side into wider memories.
// - Depth cascade by select compare, ignored in FIFO mode; unselected blocks drive zero.
module erb_embedded_ram_block #(
    parameter logic [erb_pkg::TOTAL_BITS-1:0] INIT   = '0,
    parameter int                             CAS_W  = 3,
    parameter logic [CAS_W-1:0]               CAS_ID = '0
) (
    input  wire logic                        i_clk,
    input  wire logic                        i_rst_b,
    input  wire logic [1:0]                  i_cfg_mode,
    input  wire logic [1:0]                  i_cfg_width,
    input  wire logic                        i_cfg_din_reg,
    input  wire logic                        i_cfg_dout_reg,
    input  wire logic                        i_cfg_addr_reg,
    input  wire logic                        i_cfg_we_loc,
    input  wire logic [1:0]                  i_cfg_in_src,
    input  wire logic [1:0]                  i_cfg_out_src,
    input  wire logic                        i_glb_tick,
    input  wire logic                        i_pin_clk,
    input  wire logic                        i_loc_tick,
    input  wire logic                        i_glb_we,
    input  wire logic                        i_loc_we,
    input  wire logic [erb_pkg::ADDR_W-1:0]  i_addr,
    input  wire logic [erb_pkg::DATA_W-1:0]  i_wr_data,
    input  wire logic [erb_pkg::ADDR_W-1:0]  i_rd_addr,
    input  wire logic                        i_fifo_pop,
    input  wire logic                        i_cas_en,
    input  wire logic [CAS_W-1:0]            i_cas_sel,
    output logic      [erb_pkg::DATA_W-1:0]  o_rd_data,
    output logic                             o_rd_hit,
    output logic                             o_fifo_full,
    output logic                             o_fifo_empty
);
    // Word mask for the selected organisation
    function automatic logic [erb_pkg::ROW_W-1:0] erb_mask(
        input logic [1:0] w
    );
        case (erb_pkg::erb_width_t'(w))
            erb_pkg::ERB_X8: erb_mask = 8'hff;
            erb_pkg::ERB_X4: erb_mask = 8'h0f;
            erb_pkg::ERB_X2: erb_mask = 8'h03;
            erb_pkg::ERB_X1: erb_mask = 8'h01;
            default:         erb_mask = 8'hff;
        endcase
    endfunction

    // Bit position of a word inside its storage row
    function automatic logic [erb_pkg::COL_W-1:0] erb_col(
        input logic [erb_pkg::ADDR_W-1:0] a,
        input logic [1:0]                 w
    );
        case (erb_pkg::erb_width_t'(w))
            erb_pkg::ERB_X8: erb_col = 3'h0;
            erb_pkg::ERB_X4: erb_col = {a[0], 2'h0};
            erb_pkg::ERB_X2: erb_col = {a[1:0], 1'h0};
            erb_pkg::ERB_X1: erb_col = a[2:0];
            default:         erb_col = 3'h0;
        endcase
    endfunction

    // Storage row holding a word
    function automatic logic [erb_pkg::ROW_AW-1:0] erb_row(
        input logic [erb_pkg::ADDR_W-1:0] a,
        input logic [1:0]                 w
    );
        logic [erb_pkg::ADDR_W-1:0] s;
        s       = a >> w;
        erb_row = s[erb_pkg::ROW_AW-1:0];
    endfunction

    // Clock enable source select
    function automatic logic erb_tick(
        input logic [1:0] src,
        input logic       glb,
        input logic       pin,
        input logic       loc
    );
        case (erb_pkg::erb_src_t'(src))
            erb_pkg::ERB_SRC_GLB: erb_tick = glb;
            erb_pkg::ERB_SRC_PIN: erb_tick = pin;
            erb_pkg::ERB_SRC_LOC: erb_tick = loc;
            default:              erb_tick = glb;
        endcase
    endfunction

    erb_pkg::erb_mode_t         mode;
    logic                       pin_rise;
    logic                       in_tick;
    logic                       out_tick;
    logic                       we_raw;
    logic [erb_pkg::DATA_W-1:0] din_q;
    logic [erb_pkg::ADDR_W-1:0] addr_q;
    logic [erb_pkg::ADDR_W-1:0] rd_addr_q;
    logic                       we_q;
    logic [CAS_W-1:0]           cas_q;
    logic [erb_pkg::DATA_W-1:0] din_e;
    logic [erb_pkg::ADDR_W-1:0] addr_e;
    logic [erb_pkg::ADDR_W-1:0] rd_addr_e;
    logic                       we_e;
    logic [CAS_W-1:0]           cas_e;
    logic                       match;
    logic [erb_pkg::ADDR_W-1:0] wr_ptr_q;
    logic [erb_pkg::ADDR_W-1:0] rd_ptr_q;
    logic [erb_pkg::CNT_W-1:0]  cnt_q;
    logic [erb_pkg::CNT_W-1:0]  cnt_d;
    logic [erb_pkg::CNT_W-1:0]  depth;
    logic [erb_pkg::ADDR_W-1:0] ptr_mask;
    logic                       full;
    logic                       empty;
    logic                       push;
    logic                       pop;
    logic                       wr_fire;
    logic [erb_pkg::ADDR_W-1:0] wa;
    logic [erb_pkg::ADDR_W-1:0] ra;
    logic [erb_pkg::ROW_W-1:0]  wmask;
    logic [erb_pkg::COL_W-1:0]  wcol;
    logic [erb_pkg::COL_W-1:0]  rcol;
    logic [erb_pkg::ROW_W-1:0]  row_data;
    logic [erb_pkg::ROW_W-1:0]  row_shift;
    logic [erb_pkg::DATA_W-1:0] word;
    logic                       out_upd;
    logic [erb_pkg::DATA_W-1:0] rd_data_q;
    logic                       hit_q;
    logic                       full_q;
    logic                       empty_q;

    assign mode = erb_pkg::erb_mode_t'(i_cfg_mode);

    // Pin clock: two-flop sync, one tick per rising edge
    erb_pin_sync u_pin_sync (
        .i_clk   (i_clk),
        .i_rst_b (i_rst_b),
        .i_pin   (i_pin_clk),
        .o_rise  (pin_rise)
    );

    assign in_tick  = erb_tick(i_cfg_in_src, i_glb_tick, pin_rise,
                               i_loc_tick);
    assign out_tick = erb_tick(i_cfg_out_src, i_glb_tick, pin_rise,
                               i_loc_tick);
    assign we_raw   = i_cfg_we_loc ? i_loc_we : i_glb_we;

    // Input-side registers on the input clock enable
    always_ff @(posedge i_clk) begin
        if (!i_rst_b) begin
            din_q <= 8'h00;
        end else if (in_tick) begin
            din_q <= i_wr_data;
        end
    end

    always_ff @(posedge i_clk) begin
        if (!i_rst_b) begin
            addr_q    <= 11'h000;
            rd_addr_q <= 11'h000;
            we_q      <= 1'b0;
            cas_q     <= '0;
        end else if (in_tick) begin
            addr_q    <= i_addr;
            rd_addr_q <= i_rd_addr;
            we_q      <= we_raw;
            cas_q     <= i_cas_sel;
        end
    end

    assign din_e     = i_cfg_din_reg  ? din_q     : i_wr_data;
    assign addr_e    = i_cfg_addr_reg ? addr_q    : i_addr;
    assign rd_addr_e = i_cfg_addr_reg ? rd_addr_q : i_rd_addr;
    assign we_e      = i_cfg_addr_reg ? we_q      : we_raw;
    assign cas_e     = i_cfg_addr_reg ? cas_q     : i_cas_sel;

    // Depth cascade select; FIFO storage is always local
    assign match = (mode == erb_pkg::ERB_FIFO) || !i_cas_en
                 || (cas_e == CAS_ID);

    // FIFO bookkeeping
    assign depth    = erb_pkg::BASE_DEPTH << i_cfg_width;
    assign ptr_mask = erb_pkg::FULL_MASK >> (2'h3 - i_cfg_width);
    assign full     = (cnt_q == depth);
    assign empty    = (cnt_q == 12'h000);
    assign push     = (mode == erb_pkg::ERB_FIFO) && wr_fire;
    assign pop      = (mode == erb_pkg::ERB_FIFO) && out_tick
                    && i_fifo_pop && !empty;

    // Push and pop together leave the count unchanged
    always_comb begin
        cnt_d = cnt_q;
        if (push && !pop) begin
            cnt_d = cnt_q + 12'h001;
        end else if (pop && !push) begin
            cnt_d = cnt_q - 12'h001;
        end
    end

    always_ff @(posedge i_clk) begin
        if (!i_rst_b) begin
            wr_ptr_q <= 11'h000;
            rd_ptr_q <= 11'h000;
            cnt_q    <= 12'h000;
        end else begin
            if (push) begin
                wr_ptr_q <= (wr_ptr_q + 11'h001) & ptr_mask;
            end
            if (pop) begin
                rd_ptr_q <= (rd_ptr_q + 11'h001) & ptr_mask;
            end
            cnt_q <= cnt_d;
        end
    end

    // Self-timed write: fires on the input tick, ROM never writes
    assign wr_fire = in_tick && we_e && match
                   && (mode != erb_pkg::ERB_ROM)
                   && !((mode == erb_pkg::ERB_FIFO) && full);

    // Write and read addresses for each mode
    always_comb begin
        case (mode)
            erb_pkg::ERB_FIFO: begin
                wa = wr_ptr_q;
                ra = rd_ptr_q;
            end
            erb_pkg::ERB_DPRAM: begin
                wa = addr_e;
                ra = rd_addr_e;
            end
            erb_pkg::ERB_ROM: begin
                wa = addr_e;
                ra = addr_e;
            end
            default: begin
                wa = addr_e;
                ra = addr_e;
            end
        endcase
    end

    // Word lane inside its storage row
    assign wmask = erb_mask(i_cfg_width);
    assign wcol  = erb_col(wa, i_cfg_width);
    assign rcol  = erb_col(ra, i_cfg_width);

    // 2048-bit array, written under a lane mask
    erb_store #(
        .INIT (INIT)
    ) u_store (
        .i_clk      (i_clk),
        .i_rst_b    (i_rst_b),
        .i_we       (wr_fire),
        .i_wr_row   (erb_row(wa, i_cfg_width)),
        .i_bit_mask (wmask << wcol),
        .i_bit_data ((din_e & wmask) << wcol),
        .i_rd_row   (erb_row(ra, i_cfg_width)),
        .o_rd_data  (row_data)
    );

    assign row_shift = row_data >> rcol;
    assign word      = row_shift & wmask;

    // Output stage: every cycle when bypassed, on output tick when used
    assign out_upd = i_cfg_dout_reg ? out_tick : 1'b1;

    always_ff @(posedge i_clk) begin
        if (!i_rst_b) begin
            rd_data_q <= erb_pkg::DATA_RST;
            hit_q     <= 1'b0;
        end else if (out_upd) begin
            rd_data_q <= match ? word : erb_pkg::DATA_RST;
            hit_q     <= match;
        end
    end

    // Flags follow the next count, so they move with a push or pop
    always_ff @(posedge i_clk) begin
        if (!i_rst_b) begin
            full_q  <= 1'b0;
            empty_q <= 1'b1;
        end else begin
            full_q  <= (cnt_d == depth);
            empty_q <= (cnt_d == 12'h000);
        end
    end

    assign o_rd_data    = rd_data_q;
    assign o_rd_hit     = hit_q;
    assign o_fifo_full  = full_q;
    assign o_fifo_empty = empty_q;
endmodule
`default_nettype wire

// *** dv/erb_fabric_model.sv ***
// Fabric-side user logic model: local tick and local write enable
`timescale 1ns/1ps
`default_nettype none
module erb_fabric_model (
    input  wire logic       i_clk,
    input  wire logic       i_rst_b,
    input  wire logic [3:0] i_gap,
    input  wire logic       i_req,
    output logic            o_loc_tick,
    output logic            o_loc_we,
    output logic            o_done
);
    logic [3:0] cnt_q;
    assign o_done = o_loc_tick && o_loc_we;
    // Tick every i_gap+1 cycles, a clock made by fabric logic
    always_ff @(posedge i_clk) begin
        if (!i_rst_b) begin
            cnt_q      <= 4'h0;
            o_loc_tick <= 1'h0;
        end else begin
            o_loc_tick <= cnt_q == i_gap;
            cnt_q      <= (cnt_q == i_gap) ? 4'h0 : cnt_q + 4'h1;
        end
    end
    // Enable held until a tick takes it, so setup is always met
    always_ff @(posedge i_clk) begin
        if (!i_rst_b) begin
            o_loc_we <= 1'h0;
        end else if (i_req) begin
            o_loc_we <= 1'h1;
        end else if (o_done) begin
            o_loc_we <= 1'h0;
        end
    end
endmodule
`default_nettype wire

// *** dv/erb_ram_properties.sv ***
// Assertion checker bound to the embedded RAM block
`timescale 1ns/1ps
`default_nettype none
module erb_ram_checker #(
    parameter int               CAS_W  = 3,
    parameter logic [CAS_W-1:0] CAS_ID = '0
) (
    input wire logic             i_clk,
    input wire logic             i_rst_b,
    input wire logic [1:0]       i_cfg_mode,
    input wire logic [1:0]       i_cfg_width,
    input wire logic [1:0]       i_cfg_in_src,
    input wire logic [1:0]       i_cfg_out_src,
    input wire logic             i_cfg_din_reg,
    input wire logic             i_cfg_dout_reg,
    input wire logic             i_cfg_addr_reg,
    input wire logic             i_cfg_we_loc,
    input wire logic             i_glb_tick,
    input wire logic             i_glb_we,
    input wire logic             i_cas_en,
    input wire logic [CAS_W-1:0] i_cas_sel,
    input wire logic [10:0]      i_addr,
    input wire logic [7:0]       i_wr_data,
    input wire logic [7:0]       o_rd_data,
    input wire logic             o_rd_hit,
    input wire logic             o_fifo_full,
    input wire logic             o_fifo_empty
);
    logic sel, plain, gwr;
    assign sel = !i_cas_en || i_cas_sel == CAS_ID;
    assign plain = !i_cfg_dout_reg && !i_cfg_addr_reg && !i_cfg_din_reg;
    assign gwr = i_cfg_in_src == 2'h0 && !i_cfg_we_loc && i_glb_tick
        && i_glb_we && sel && plain;
    default clocking chk_cb @(posedge i_clk);
    endclocking
    default disable iff (!i_rst_b);
    reset_clear_a: assert property ($rose(i_rst_b) |-> o_fifo_empty
        && !o_fifo_full && !o_rd_hit && o_rd_data == 8'h00)
        else $error("outputs not cleared");
    flag_excl_a: assert property (!(o_fifo_full && o_fifo_empty))
        else $error("full and empty together");
    unsel_zero_a: assert property (plain && !sel |=>
        o_rd_data == 8'h00 && !o_rd_hit) else $error("unselected drives");
    sel_hit_a: assert property (plain && sel |=> o_rd_hit)
        else $error("selected block shows no hit");
    out_hold_a: assert property (i_cfg_dout_reg &&
        i_cfg_out_src == 2'h0 && !i_glb_tick |=> $stable(o_rd_data))
        else $error("output moved without tick");
    rom_hold_a: assert property (i_cfg_mode == 2'h1 && plain && sel &&
        $stable(i_addr) && $stable(i_cfg_mode) && $stable(i_cfg_width)
        && $past(i_rst_b) |=> $stable(o_rd_data)) else $error("rom changed");
    wr_rd_a: assert property (i_cfg_mode == 2'h0 && i_cfg_width == 2'h0
        && gwr ##1 ($stable(i_addr) && !i_glb_we && sel)
        |=> o_rd_data == $past(i_wr_data, 2)) else $error("write lost");
    x1_mask_a: assert property (i_cfg_width == 2'h3 &&
        $stable(i_cfg_width) && !i_cfg_dout_reg |=> o_rd_data[7:1] == 7'h00)
        else $error("unused bits set");
    push_flag_a: assert property (i_cfg_mode == 2'h2 && gwr
        |-> ##[1:2] !o_fifo_empty) else $error("empty after push");
endmodule
bind erb_embedded_ram_block erb_ram_checker #(.CAS_W(CAS_W), .CAS_ID(CAS_ID))
    erb_ram_checker_inst (.i_clk(i_clk), .i_rst_b(i_rst_b),
    .i_cfg_mode(i_cfg_mode), .i_cfg_width(i_cfg_width),
    .i_cfg_in_src(i_cfg_in_src), .i_cfg_out_src(i_cfg_out_src),
    .i_cfg_din_reg(i_cfg_din_reg), .i_cfg_dout_reg(i_cfg_dout_reg),
    .i_cfg_addr_reg(i_cfg_addr_reg), .i_cfg_we_loc(i_cfg_we_loc),
    .i_glb_tick(i_glb_tick), .i_glb_we(i_glb_we), .i_cas_en(i_cas_en),
    .i_cas_sel(i_cas_sel), .i_addr(i_addr), .i_wr_data(i_wr_data),
    .o_rd_data(o_rd_data), .o_rd_hit(o_rd_hit),
    .o_fifo_full(o_fifo_full), .o_fifo_empty(o_fifo_empty));
`default_nettype wire

// *** dv/erb_embedded_ram_block_tb_top.sv ***
// Self-checking bench for the embedded RAM block
`timescale 1ns/1ps
`default_nettype none
module erb_embedded_ram_block_tb_top;
    localparam logic [2:0] MY_ID = 3'h5;
    logic        i_clk, i_rst_b, i_cfg_din_reg, i_cfg_dout_reg, i_cfg_addr_reg;
    logic        i_cfg_we_loc, i_glb_tick, i_pin_clk, i_glb_we, i_fifo_pop;
    logic        i_cas_en, loc_tick, loc_we, fab_req, fab_done;
    logic        o_rd_hit, o_fifo_full, o_fifo_empty;
    logic [1:0]  i_cfg_mode, i_cfg_width, i_cfg_in_src, i_cfg_out_src;
    logic [2:0]  i_cas_sel, seen;
    logic [10:0] i_addr, i_rd_addr, a;
    logic [7:0]  i_wr_data, o_rd_data, d, m, mem [256];
    logic [31:0] seed;
    int          fails = 0, total_checks = 0, cycles = 0, n, o;

    function automatic logic [2047:0] rom_pat();
        logic [2047:0] p;
        for (int i = 0; i < 256; i++) p[i*8 +: 8] = 8'(i) ^ 8'h5a;
        return p;
    endfunction
    function automatic logic [31:0] xs(input logic [31:0] s);
        logic [31:0] t;
        t = s ^ (s << 13);
        t = t ^ (t >> 17);
        return t ^ (t << 5);
    endfunction
    task automatic check(input logic [7:0] got, input logic [7:0] exp);
        total_checks++;
        if (got !== exp) begin
            fails++;
            $display("ERROR %0t: got %h, expected %h", $time, got, exp);
        end
    endtask
    task automatic end_of_test();
        $display("checks %0d, mismatches %0d", total_checks, fails);
        if (fails == 0 && total_checks > 0) begin
            $display("RESULT: PASS");
        end else begin
            $display("RESULT: FAIL");
        end
        $finish;
    endtask
    task automatic wr(input logic [10:0] wa, input logic [7:0] wd);
        i_addr    <= wa;
        i_wr_data <= wd;
        i_glb_we  <= 1'h1;
        @(posedge i_clk);
    endtask
    task automatic rd(input logic [10:0] ra, input logic [7:0] exp);
        i_addr    <= ra;
        i_rd_addr <= ra;
        i_glb_we  <= 1'h0;
        repeat (8) @(posedge i_clk);
        #1 check(o_rd_data, exp);
        seen = {o_fifo_full, o_fifo_empty, o_rd_hit};
        @(posedge i_clk);
    endtask

    erb_embedded_ram_block #(.INIT(rom_pat()), .CAS_ID(MY_ID))
        erb_embedded_ram_block_inst (.i_clk(i_clk), .i_rst_b(i_rst_b),
        .i_cfg_mode(i_cfg_mode), .i_cfg_width(i_cfg_width),
        .i_cfg_din_reg(i_cfg_din_reg), .i_cfg_dout_reg(i_cfg_dout_reg),
        .i_cfg_addr_reg(i_cfg_addr_reg), .i_cfg_we_loc(i_cfg_we_loc),
        .i_cfg_in_src(i_cfg_in_src), .i_cfg_out_src(i_cfg_out_src),
        .i_glb_tick(i_glb_tick), .i_pin_clk(i_pin_clk),
        .i_loc_tick(loc_tick), .i_glb_we(i_glb_we), .i_loc_we(loc_we),
        .i_addr(i_addr), .i_wr_data(i_wr_data), .i_rd_addr(i_rd_addr),
        .i_fifo_pop(i_fifo_pop), .i_cas_en(i_cas_en), .i_cas_sel(i_cas_sel),
        .o_rd_data(o_rd_data), .o_rd_hit(o_rd_hit),
        .o_fifo_full(o_fifo_full), .o_fifo_empty(o_fifo_empty));
    erb_fabric_model erb_fabric_model_inst (.i_clk(i_clk), .i_rst_b(i_rst_b),
        .i_gap(4'h2), .i_req(fab_req), .o_loc_tick(loc_tick),
        .o_loc_we(loc_we), .o_done(fab_done));

    initial begin
        i_clk = 1'h0;
        forever #4 i_clk = ~i_clk;
    end
    always @(posedge i_clk) begin
        cycles <= cycles + 1;
        if (cycles == 5000) begin
            fails++;
            end_of_test();
        end
    end

    initial begin
        {i_rst_b, i_cfg_din_reg, i_cfg_dout_reg, i_cfg_addr_reg} = '0;
        {i_cfg_we_loc, i_pin_clk, i_glb_we, i_fifo_pop, i_cas_en} = '0;
        {i_cfg_mode, i_cfg_width, i_cfg_in_src, i_cfg_out_src} = 8'h40;
        {i_cas_sel, i_addr, i_rd_addr, i_wr_data, fab_req} = '0;
        i_glb_tick = 1'h1;
        seed = 32'h00018625;
        for (int i = 0; i < 256; i++) mem[i] = 8'(i) ^ 8'h5a;
        repeat (4) @(posedge i_clk);
        i_rst_b <= 1'h1;
        #1 check({5'h00, o_fifo_full, o_fifo_empty, o_rd_hit}, 8'h02);
        @(posedge i_clk);
        wr(11'h007, 8'hff);
        rd(11'h007, 8'h5d);
        i_cfg_mode <= 2'h0;
        for (int i = 0; i < 6; i++) begin
            seed = xs(seed);
            mem[seed[7:0]] = seed[15:8];
            mem[seed[23:16]] = seed[31:24];
            wr({3'h0, seed[7:0]}, seed[15:8]);
            wr({3'h0, seed[23:16]}, seed[31:24]);
            rd({3'h0, seed[23:16]}, mem[seed[23:16]]);
            rd({3'h0, seed[7:0]}, mem[seed[7:0]]);
        end
        for (int w = 1; w < 4; w++) begin
            i_cfg_width <= 2'(w);
            for (int i = 0; i < 4; i++) begin
                seed = xs(seed);
                a = seed[10:0] & 11'((12'h100 << w) - 12'h1);
                d = seed[18:11];
                n = 8 >> w;
                o = (int'(a) % (1 << w)) * n;
                m = 8'(((1 << n) - 1) << o);
                mem[a >> w] = (mem[a >> w] & ~m) | ((d << o) & m);
                wr(a, d);
                rd(a, (mem[a >> w] & m) >> o);
            end
        end
        i_cfg_width <= 2'h0;
        rd({3'h0, a[10:3]}, mem[a[10:3]]);
        i_cas_en  <= 1'h1;
        i_cas_sel <= MY_ID ^ 3'h1;
        wr(11'h010, ~mem[16]);
        rd(11'h010, 8'h00);
        check({7'h00, seen[0]}, 8'h00);
        i_cas_sel <= MY_ID;
        rd(11'h010, mem[16]);
        check({7'h00, seen[0]}, 8'h01);
        i_cfg_mode <= 2'h3;
        wr(11'h021, 8'hc3);
        rd(11'h021, 8'hc3);
        i_cfg_mode <= 2'h0;
        {i_cfg_din_reg, i_cfg_dout_reg, i_cfg_addr_reg} <= 3'h7;
        wr(11'h042, 8'h96);
        rd(11'h042, 8'h96);
        i_glb_tick <= 1'h0;
        rd(11'h010, 8'h96);
        i_glb_tick <= 1'h1;
        rd(11'h010, mem[16]);
        {i_cfg_din_reg, i_cfg_dout_reg, i_cfg_addr_reg} <= 3'h0;
        {i_cfg_we_loc, i_cfg_in_src, i_cfg_out_src} <= 5'h1f;
        i_addr    <= 11'h055;
        i_wr_data <= 8'h3e;
        fab_req   <= 1'h1;
        @(posedge i_clk);
        fab_req <= 1'h0;
        for (n = 0; n < 20 && fab_done !== 1'h1; n++) @(posedge i_clk);
        rd(11'h055, 8'h3e);
        {i_cfg_we_loc, i_cfg_in_src, i_cfg_out_src} <= 5'h05;
        i_addr    <= 11'h066;
        i_wr_data <= 8'h81;
        i_glb_we  <= 1'h1;
        i_pin_clk <= 1'h1;
        repeat (4) @(posedge i_clk);
        i_pin_clk <= 1'h0;
        rd(11'h066, 8'h81);
        {i_cfg_we_loc, i_cfg_in_src, i_cfg_out_src} <= 5'h00;
        i_cfg_mode <= 2'h2;
        i_rst_b    <= 1'h0;
        repeat (4) @(posedge i_clk);
        i_rst_b <= 1'h1;
        for (int i = 0; i < 256; i++) wr(11'h000, 8'(i) ^ 8'h3c);
        wr(11'h000, 8'ha5);
        rd(11'h000, 8'h3c);
        check({6'h00, seen[2:1]}, 8'h02);
        for (int i = 0; i < 256; i++) begin
            #1 check(o_rd_data, 8'(i) ^ 8'h3c);
            @(posedge i_clk);
            i_fifo_pop <= 1'h1;
            @(posedge i_clk);
            i_fifo_pop <= 1'h0;
            repeat (2) @(posedge i_clk);
        end
        #1 check({6'h00, o_fifo_full, o_fifo_empty}, 8'h01);
        end_of_test();
    end
endmodule
`default_nettype wire
